//--- logic/mmtb_pkg.sv
// Shared constants for the monitor multiplexer and thermistor bias control.
// Assumes a Wishbone classic slave with 32-bit data and word-aligned registers.
package mmtb_pkg;
   // Register byte addresses
   localparam logic [7:0] MMTB_ADDR_MUX    = 8'h00;
   localparam logic [7:0] MMTB_ADDR_THRESH = 8'h04;
   localparam logic [7:0] MMTB_ADDR_CTRL   = 8'h08;
   localparam logic [7:0] MMTB_ADDR_STATUS = 8'h0c;
   // Channel select codes
   localparam logic [3:0] MMTB_SEL_OFF      = 4'h0;
   localparam logic [3:0] MMTB_SEL_CHG_V    = 4'h1;
   localparam logic [3:0] MMTB_SEL_CHG_I    = 4'h2;
   localparam logic [3:0] MMTB_SEL_BAT_V    = 4'h3;
   localparam logic [3:0] MMTB_SEL_BAT_ICHG = 4'h4;
   localparam logic [3:0] MMTB_SEL_BAT_IDIS = 4'h5;
   localparam logic [3:0] MMTB_SEL_NULL     = 4'h6;
   localparam logic [3:0] MMTB_SEL_THERM    = 4'h7;
   localparam logic [3:0] MMTB_SEL_THERMISTOR_BIAS_PIN    = 4'h8;
   localparam logic [3:0] MMTB_SEL_GND      = 4'h9;
   localparam logic [3:0] MMTB_SEL_SYS      = 4'ha;
   localparam int         MMTB_NUM_CH       = 10;
   // Threshold field positions in the threshold register
   localparam int MMTB_HOT_POS  = 0;
   localparam int MMTB_WARM_POS = 2;
   localparam int MMTB_COOL_POS = 4;
   localparam int MMTB_COLD_POS = 6;
   // Control bit positions
   localparam int MMTB_CTRL_TSEN_POS = 0;
   // Reset values
   localparam logic [3:0] MMTB_RST_SEL    = 4'h0;
   localparam logic [7:0] MMTB_RST_THRESH = 8'h00;
   localparam logic       MMTB_RST_TSEN   = 1'b0;
endpackage

//--- logic/mmtb_decode.sv
// Channel decoder: one-hot route enables from the channel select.
// Assumes select is registered by the caller.
`timescale 1ns/1ps
`default_nettype none
module mmtb_decode (
   input  wire logic [3:0]  sel_i,
   input  wire logic        bias_ok_i,
   output logic      [9:0]  route_o,
   output logic             buf_en_o
);
   genvar g;
   generate
      for (g = 0; g < mmtb_pkg::MMTB_NUM_CH; g++) begin : g_ch
         // Codes 1..10 map to bits 0..9; others route nothing, see R15
         assign route_o[g] = bias_ok_i && (sel_i == 4'(g + 1)); // see R5 see R6 see R7 see R8
      end
   endgenerate
   assign buf_en_o = |route_o; // see R3
endmodule
`default_nettype wire

//--- logic/mmtb_bias.sv
// Thermistor bias decision logic.
// Assumes the charger input valid flag is synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module mmtb_bias (
   input  wire logic        chg_valid_i,
   input  wire logic        temp_sense_enable_i,
   input  wire logic [3:0]  sel_i,
   output logic             bias_on_o
);
   // Either source of demand biases the divider; none turns it off, see R14
   assign bias_on_o = (chg_valid_i && temp_sense_enable_i)          // see R9
                    || (sel_i == mmtb_pkg::MMTB_SEL_THERM)          // see R10
                    || (sel_i == mmtb_pkg::MMTB_SEL_THERMISTOR_BIAS_PIN);
endmodule
`default_nettype wire

//--- logic/mmtb_top.sv
// Monitor multiplexer and thermistor bias control with a Wishbone slave.
// Assumes one clock, synchronous active-high reset, synchronous inputs.
// Behaviour
// R1 - A 4-bit channel select picks one internal signal for the monitor pin.
// R2 - Select zero disables the multiplexer and floats the monitor pin.
// R3 - Buffer on only with main bias active and select nonzero.
// R4 - Software writes zero to the select when not converting.
// R5 - Codes 1, 2, 10 route charger voltage, charger current, system rail.
// R6 - Codes 3 and 4 route battery voltage and charging current.
// R7 - Codes 5 and 6 route discharge current and its offset-null reference.
// R8 - Codes 7, 8, 9 route thermistor sense, bias, analog ground.
// R9 - Bias on when charger input valid and temperature sensing enabled.
// R10 - Bias on when a thermistor channel is selected.
// R11 - Select changes never disturb temperature comparators or charge adjustment.
// R12 - Four independent 2-bit fields select hot, warm, cool, cold trips.
// R13 - Each field picks a tabulated trip voltage, 1.024 V down to 0.291 V.
// R14 - Bias off when neither bias condition holds.
// R15 - Select codes above ten behave like zero.
`timescale 1ns/1ps
`default_nettype none
module mmtb_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        main_bias_ok_i,
   input  wire logic        chg_valid_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic      [9:0]  route_en_o,
   output logic             monitor_output_pin_oe_o,
   output logic             thermistor_bias_pin_en_o,
   output logic      [1:0]  hot_threshold_select_o,
   output logic      [1:0]  warm_threshold_select_o,
   output logic      [1:0]  cool_threshold_select_o,
   output logic      [1:0]  cold_threshold_select_o,
   output logic             temp_sense_enable_o
);
   typedef struct packed {
      logic [3:0]  sel;
      logic [7:0]  thresh;
      logic        tsen;
      logic        ack;
      logic [31:0] dat;
      logic [9:0]  route;
      logic        oe;
      logic        bias;
   } mmtb_state_s;

   mmtb_state_s state_reg;
   mmtb_state_s state_next;

   logic [9:0] route_w;
   logic       buf_w;
   logic       bias_w;
   logic       req_w;

   // Decode from the registered select so outputs settle one cycle after a write
   mmtb_decode u_decode (
      .sel_i     (state_reg.sel),
      .bias_ok_i (main_bias_ok_i),
      .route_o   (route_w),
      .buf_en_o  (buf_w)
   );

   mmtb_bias u_bias (
      .chg_valid_i         (chg_valid_i),
      .temp_sense_enable_i (state_reg.tsen),
      .sel_i               (state_reg.sel),
      .bias_on_o           (bias_w)
   );

   assign req_w = wb_cyc_i && wb_stb_i && !state_reg.ack;

   always_comb begin
      state_next = state_reg;
      state_next.ack = req_w;
      state_next.route = route_w;   // see R1 see R2
      state_next.oe = buf_w;        // see R2 see R3 see R15
      state_next.bias = bias_w;     // see R9 see R10 see R14
      if (req_w && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            mmtb_pkg::MMTB_ADDR_MUX: begin
               state_next.sel = wb_dat_i[3:0];   // see R1
            end
            mmtb_pkg::MMTB_ADDR_THRESH: begin
               state_next.thresh = wb_dat_i[7:0]; // see R12
            end
            mmtb_pkg::MMTB_ADDR_CTRL: begin
               state_next.tsen = wb_dat_i[mmtb_pkg::MMTB_CTRL_TSEN_POS];
            end
            default: begin
               state_next.sel = state_reg.sel;
            end
         endcase
      end
      state_next.dat = 32'h0000_0000;
      if (req_w && !wb_we_i) begin
         case (wb_adr_i)
            mmtb_pkg::MMTB_ADDR_MUX:    state_next.dat = {28'h0, state_reg.sel};
            mmtb_pkg::MMTB_ADDR_THRESH: state_next.dat = {24'h0, state_reg.thresh};
            mmtb_pkg::MMTB_ADDR_CTRL:   state_next.dat = {31'h0, state_reg.tsen};
            mmtb_pkg::MMTB_ADDR_STATUS: state_next.dat = {20'h0, state_reg.route, state_reg.oe, state_reg.bias};
            default:                    state_next.dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg.sel    <= mmtb_pkg::MMTB_RST_SEL;
         state_reg.thresh <= mmtb_pkg::MMTB_RST_THRESH;
         state_reg.tsen   <= mmtb_pkg::MMTB_RST_TSEN;
         state_reg.ack    <= 1'b0;
         state_reg.dat    <= 32'h0000_0000;
         state_reg.route  <= 10'h000;
         state_reg.oe     <= 1'b0;
         state_reg.bias   <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
      end
   end

   assign wb_dat_o                 = state_reg.dat;
   assign wb_ack_o                 = state_reg.ack;
   assign route_en_o               = state_reg.route;
   assign monitor_output_pin_oe_o  = state_reg.oe;
   assign thermistor_bias_pin_en_o = state_reg.bias;
   // Threshold fields leave the block directly; the select never touches them, see R11 see R13
   assign hot_threshold_select_o   = state_reg.thresh[mmtb_pkg::MMTB_HOT_POS +: 2];
   assign warm_threshold_select_o  = state_reg.thresh[mmtb_pkg::MMTB_WARM_POS +: 2];
   assign cool_threshold_select_o  = state_reg.thresh[mmtb_pkg::MMTB_COOL_POS +: 2];
   assign cold_threshold_select_o  = state_reg.thresh[mmtb_pkg::MMTB_COLD_POS +: 2];
   assign temp_sense_enable_o      = state_reg.tsen;
endmodule
`default_nettype wire

//--- tb/mmtb_checker.sv
// Assertions on the monitor mux control ports.
// Bound into mmtb_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module mmtb_checker (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       ce_i,
   input wire logic       main_bias_ok_i,
   input wire logic       chg_valid_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic       wb_ack_o,
   input wire logic [9:0] route_en_o,
   input wire logic       monitor_output_pin_oe_o,
   input wire logic       thermistor_bias_pin_en_o,
   input wire logic       temp_sense_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   single_route_a: assert property ($onehot0(route_en_o)) else $error("two routes");
   oe_route_a: assert property (monitor_output_pin_oe_o == (route_en_o != 10'h000)) else $error("oe");
   oe_bias_a: assert property ($past(ce_i) && !$past(main_bias_ok_i) |-> !monitor_output_pin_oe_o)
      else $error("oe without bias");
   therm_bias_a: assert property (|route_en_o[7:6] |-> thermistor_bias_pin_en_o) else $error("bias");
   sense_bias_a: assert property ($past(ce_i && chg_valid_i && temp_sense_enable_o) |-> thermistor_bias_pin_en_o)
      else $error("sense bias");
   bias_off_a: assert property ($past(ce_i && main_bias_ok_i && !(chg_valid_i && temp_sense_enable_o))
      && route_en_o[7:6] == 2'b00 |-> !thermistor_bias_pin_en_o) else $error("bias stuck");
   ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack long");
   ack_answer_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   sense_hold_a: assert property ($changed(temp_sense_enable_o)
      |-> $past(wb_we_i && wb_stb_i && wb_adr_i == mmtb_pkg::MMTB_ADDR_CTRL)) else $error("sense moved");
endmodule
bind mmtb_top mmtb_checker u_chk (.*);
`default_nettype wire

//--- tb/mmtb_adc_model.sv
// Converter model on the monitor pin: reports the channel it sees.
// Zero while the pin floats, since a floating pin carries no code.
`timescale 1ns/1ps
`default_nettype none
module mmtb_adc_model (
   input  wire logic       clk_i,
   input  wire logic       oe_i,
   input  wire logic [9:0] route_i,
   output logic      [3:0] code_o
);
   always_ff @(posedge clk_i) begin
      code_o <= 4'h0;
      for (int k = 0; k < 10; k++) begin
         if (oe_i && route_i[k]) code_o <= 4'(k + 1);
      end
   end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Bench for mmtb_top with a converter model on the monitor pin.
// Wishbone classic master; wb_sel_i is tied, ce_i is driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1, ce = 1'b1, mb = 1'b0, cv = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, rd, dat_o;
   logic ack, oe, bias, tse;
   logic [9:0] route;
   logic [1:0] hot, warm, cool, cold;
   logic [3:0] code;
   int error_cnt = 0;
   int comparisons = 0;
   always #50 clk_i = ~clk_i;
   mmtb_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .main_bias_ok_i(mb), .chg_valid_i(cv),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .route_en_o(route), .monitor_output_pin_oe_o(oe),
      .thermistor_bias_pin_en_o(bias), .hot_threshold_select_o(hot), .warm_threshold_select_o(warm),
      .cool_threshold_select_o(cool), .cold_threshold_select_o(cold), .temp_sense_enable_o(tse));
   mmtb_adc_model adc (.clk_i(clk_i), .oe_i(oe), .route_i(route), .code_o(code));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Held until ack is sampled; the idle edges let derived outputs settle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      check(32'(ack), 32'h1);
      rd = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic t_reset;
      check(32'({route, oe, bias, hot, warm, cool, cold, tse}), 32'h0);
      bus(1'b0, mmtb_pkg::MMTB_ADDR_STATUS, 32'h0);
      check(rd, 32'h0);
   endtask
   task automatic t_sweep;
      logic [3:0] e;
      @(posedge clk_i) mb <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, mmtb_pkg::MMTB_ADDR_MUX, 32'(c));
         e = (c >= 1 && c <= 10) ? 4'(c) : 4'h0;
         check(32'(code), 32'(e));
         check(32'(oe), 32'(e != 4'h0));
         check(32'(bias), 32'(c == 7 || c == 8));
      end
   endtask
   task automatic t_bias;
      @(posedge clk_i) mb <= 1'b0;
      bus(1'b1, mmtb_pkg::MMTB_ADDR_MUX, 32'h7);
      check(32'({route, oe, bias}), 32'h001);
      bus(1'b0, mmtb_pkg::MMTB_ADDR_STATUS, 32'h0);
      check(rd, 32'h1);
      // Clock enable low must hold the derived outputs although main bias comes up
      @(posedge clk_i);
      ce <= 1'b0;
      mb <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      check(32'({route, oe, bias}), 32'h001);
      @(posedge clk_i);
      ce <= 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      check(32'({route, oe, bias}), 32'h103);
      @(posedge clk_i);
      mb <= 1'b0;
      bus(1'b1, mmtb_pkg::MMTB_ADDR_MUX, 32'h0);
      @(posedge clk_i) cv <= 1'b1;
      bus(1'b1, mmtb_pkg::MMTB_ADDR_CTRL, 32'h1);
      check(32'({tse, bias}), 32'h3);
      @(posedge clk_i) cv <= 1'b0;
      bus(1'b0, mmtb_pkg::MMTB_ADDR_CTRL, 32'h0);
      check(32'({rd[0], bias}), 32'h2);
   endtask
   task automatic t_thresh;
      bus(1'b1, mmtb_pkg::MMTB_ADDR_THRESH, 32'he4);
      bus(1'b1, mmtb_pkg::MMTB_ADDR_MUX, 32'h8);
      bus(1'b1, 8'h10, 32'hff);
      bus(1'b0, 8'h10, 32'h0);
      check(32'({rd[7:0], cold, cool, warm, hot, tse}), 32'h1c9);
      bus(1'b0, mmtb_pkg::MMTB_ADDR_THRESH, 32'h0);
      check(rd, 32'he4);
   endtask
   task automatic summarize;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      t_reset;
      t_sweep;
      t_bias;
      t_thresh;
      summarize;
   end
   // About 180 cycles are needed; the margin covers slow acks
   initial begin
      repeat (2000) @(posedge clk_i);
      error_cnt++;
      summarize;
   end
endmodule
`default_nettype wire
